/* File: sim/irq_bank_assertions.sv */
// Purpose: port-level checks for the flag and enable bank
// Assumes: bound to every instance of the bank
// Notes: enables are not visible here, so gating checks are one-sided
`timescale 1ns/100ps
module irq_bank_checker (
  // clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // register bus
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  // request side
  input wire logic [15:0] PEND0_I,
  input wire logic [15:0] PEND1_I,
  input wire logic [15:0] PEND2_I,
  input wire logic [15:0] FWD0_O,
  input wire logic [15:0] FWD1_O,
  input wire logic [15:0] FWD2_O,
  input wire logic [15:0] FWD4_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  a_write_answer: assert property (
    (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I &&
    S_AXI_WREADY_O) |-> ##2 S_AXI_BVALID_O)
    else $error("write answer late");
  a_write_refused: assert property (
    S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken while answering");
  a_read_answer: assert property (
    (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
    |-> !S_AXI_RVALID_O ##1 !S_AXI_RVALID_O ##1 S_AXI_RVALID_O)
    else $error("read answer timing wrong");
  a_read_upper: assert property (
    S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:16] == 16'h0000)
    else $error("upper read half not zero");
  // gating: a forward bit needs its pending level one cycle before
  a_fwd_gated: assert property (
    ((FWD0_O & ~$past(PEND0_I)) | (FWD1_O & ~$past(PEND1_I)) |
    (FWD2_O & ~$past(PEND2_I))) == 16'h0000)
    else $error("forward without pending level");
  a_spare_enable: assert property (
    !FWD0_O[15] && !FWD1_O[2] && !FWD2_O[13])
    else $error("forward on unimplemented enable");
  a_spare_flag: assert property (
    (FWD4_O & ~ibk_pkg::MASK_F4) == 16'h0000)
    else $error("forward on unimplemented flag");
  a_reset_clear: assert property (
    $rose(NRST_I) |-> ((FWD0_O | FWD1_O | FWD2_O | FWD4_O) == 16'h0000) &&
    !S_AXI_BVALID_O && !S_AXI_RVALID_O)
    else $error("state not clear after reset");
endmodule // irq_bank_checker

bind irq_flag_enable_bank irq_bank_checker u_chk (
  .CLK_I(CLK_I),
  .NRST_I(NRST_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
  .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WVALID_I(S_AXI_WVALID_I),
  .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O),
  .PEND0_I(PEND0_I),
  .PEND1_I(PEND1_I),
  .PEND2_I(PEND2_I),
  .FWD0_O(FWD0_O),
  .FWD1_O(FWD1_O),
  .FWD2_O(FWD2_O),
  .FWD4_O(FWD4_O)
);

/* File: sim/irq_source_model.sv */
// Purpose: peripheral request sources facing the bank
// Assumes: tasks are called just after a rising edge
// Notes: one pending level feeds all three groups
`timescale 1ns/100ps
module irq_source_model (
  // clock
  input wire logic clk_i,
  // request lines
  output logic [5:0] req_o,
  output logic [15:0] pend_o
);
  logic [5:0] req_reg = 6'h00;
  logic [15:0] pend_reg = 16'h0000;
  assign req_o = req_reg;
  assign pend_o = pend_reg;
  // one-cycle pulse, a held level would hide set-versus-clear races
  task automatic fire(input logic [5:0] m);
    req_reg <= m;
    @(posedge clk_i);
    req_reg <= 6'h00;
  endtask
  task automatic set_pend(input logic [15:0] v);
    pend_reg <= v;
  endtask
endmodule // irq_source_model

/* File: sim/test_irq_flag_enable_bank.sv */
// Purpose: register and forwarding tests for the flag and enable bank
// Assumes: AXI4-Lite master tasks, source model drives requests
// Notes: expectations come from the package masks and offsets
`timescale 1ns/100ps
module test_irq_flag_enable_bank;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awv = 1'b0;
  logic [7:0] awa = 8'h00;
  logic wv = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'h0;
  logic br = 1'b0;
  logic arv = 1'b0;
  logic [7:0] ara = 8'h00;
  logic rr = 1'b0;
  logic awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [5:0] req;
  logic [15:0] pend;
  wire [3:0][15:0] fwd;
  logic [7:0] addrs [5];
  logic [15:0] masks [5];
  int fpos [6] = '{1, 2, 4, 5, 6, 7};
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int i, g, b;
  always #2 clk = ~clk;
  irq_source_model src (.clk_i(clk), .req_o(req), .pend_o(pend));
  irq_flag_enable_bank dut (
    .CLK_I(clk), .NRST_I(rst_n),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWPROT_I(3'h0), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(br), .S_AXI_BRESP_O(bresp),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara),
    .S_AXI_ARPROT_I(3'h0), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .CAN_B_TX_REQ_I(req[5]), .CAN_A_TX_REQ_I(req[4]),
    .DMA_CH7_DONE_I(req[3]), .DMA_CH6_DONE_I(req[2]),
    .UART_B_ERR_I(req[1]), .UART_A_ERR_I(req[0]),
    .PEND0_I(pend), .PEND1_I(pend), .PEND2_I(pend),
    .FWD0_O(fwd[0]), .FWD1_O(fwd[1]), .FWD2_O(fwd[2]), .FWD4_O(fwd[3])
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] exp_resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    ws <= s;
    br <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awr === 1'b1) begin
        aw_done = 1'b1;
        awv <= 1'b0;
      end
      if (!w_done && wr === 1'b1) begin
        w_done = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    br <= 1'b0;
    check({30'h0, bresp}, {30'h0, exp_resp});
    @(posedge clk);
  endtask
  task automatic axi_read(input logic [7:0] a, input logic [31:0] exp,
    input logic [1:0] exp_resp);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rr <= 1'b0;
    check(rdata, exp);
    check({30'h0, rresp}, {30'h0, exp_resp});
    @(posedge clk);
  endtask
  // hang guard, about twelve times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    addrs = '{ibk_pkg::OFF_FLAGS4, ibk_pkg::OFF_EN0, ibk_pkg::OFF_EN1,
      ibk_pkg::OFF_EN2, ibk_pkg::OFF_EN4};
    masks = '{ibk_pkg::MASK_F4, ibk_pkg::MASK_E0, ibk_pkg::MASK_E1,
      ibk_pkg::MASK_E2, ibk_pkg::MASK_E4};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 5; i++) begin
      axi_read(addrs[i], 32'h0, ibk_pkg::RESP_OKAY);
    end
    axi_write(8'h14, 32'hFFFFFFFF, 4'hF, ibk_pkg::RESP_SLVERR);
    axi_read(8'h14, 32'h0, ibk_pkg::RESP_SLVERR);
    for (i = 0; i < 5; i++) begin
      axi_write(addrs[i], 32'hFFFFFFFF, 4'hF, ibk_pkg::RESP_OKAY);
      axi_read(addrs[i], {16'h0, masks[i]}, ibk_pkg::RESP_OKAY);
      axi_write(addrs[i], 32'h0, 4'hF, ibk_pkg::RESP_OKAY);
      axi_read(addrs[i], 32'h0, ibk_pkg::RESP_OKAY);
    end
    // low strobe only, upper byte keeps zero
    axi_write(ibk_pkg::OFF_EN0, 32'hFFFF, 4'h1, ibk_pkg::RESP_OKAY);
    axi_read(ibk_pkg::OFF_EN0, 32'h00FF, ibk_pkg::RESP_OKAY);
    src.set_pend(16'hFFFF);
    for (g = 0; g < 3; g++) begin
      for (b = 0; b < 16; b++) begin
        axi_write(addrs[g + 1], {16'h0, 16'h1 << b}, 4'hF,
          ibk_pkg::RESP_OKAY);
        check({16'h0, fwd[g]}, {16'h0, (16'h1 << b) & masks[g + 1]});
      end
      axi_write(addrs[g + 1], 32'hFFFF, 4'hF, ibk_pkg::RESP_OKAY);
    end
    // pending level follows through open enables, one cycle late
    src.set_pend(16'h5A5A);
    repeat (2) @(posedge clk);
    for (g = 0; g < 3; g++) begin
      check({16'h0, fwd[g]}, {16'h0, 16'h5A5A & masks[g + 1]});
    end
    for (i = 0; i < 6; i++) begin
      src.fire(6'h1 << i);
      axi_read(ibk_pkg::OFF_FLAGS4, 32'h1 << fpos[i],
        ibk_pkg::RESP_OKAY);
      check({16'h0, fwd[3]}, 32'h0);
      axi_write(ibk_pkg::OFF_EN4, 32'h1 << fpos[i], 4'hF,
        ibk_pkg::RESP_OKAY);
      check({16'h0, fwd[3]}, 32'h1 << fpos[i]);
      axi_write(ibk_pkg::OFF_FLAGS4, 32'h0, 4'hF, ibk_pkg::RESP_OKAY);
      axi_read(ibk_pkg::OFF_FLAGS4, 32'h0, ibk_pkg::RESP_OKAY);
      axi_write(ibk_pkg::OFF_EN4, 32'h0, 4'hF, ibk_pkg::RESP_OKAY);
    end
    // request lands on the same edge as a clearing write
    fork
      axi_write(ibk_pkg::OFF_FLAGS4, 32'h0, 4'hF, ibk_pkg::RESP_OKAY);
      begin
        do @(posedge clk); while (awr !== 1'b1);
        src.fire(6'h20);
      end
    join
    axi_read(ibk_pkg::OFF_FLAGS4, 32'h80, ibk_pkg::RESP_OKAY);
    // reset in mid-run must clear live flags and enables
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 4; i++) begin
      axi_read(addrs[i], 32'h0, ibk_pkg::RESP_OKAY);
    end
    check({16'h0, fwd[0]}, 32'h0);
    complete_run();
  end
endmodule // test_irq_flag_enable_bank

/* File: src/axil_reg_port.sv */
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: register file answers combinationally
// Notes: address and data may arrive in either order
`timescale 1ns/100ps
module axil_reg_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // write channels
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [7:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // read channels
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [7:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // register file side
  output ibk_pkg::reg_wr_t wr_o,
  output ibk_pkg::reg_rd_t rd_o,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_err_i,
  input wire logic wr_err_i
);
  logic aw_full_reg, w_full_reg, ar_full_reg;
  logic [7:0] awaddr_reg, araddr_reg;
  logic [15:0] wdata_reg;
  logic [1:0] wstrb_reg;
  wire aw_take = awvalid_i & awready_o;
  wire w_take = wvalid_i & wready_o;
  wire ar_take = arvalid_i & arready_o;
  wire wr_fire = aw_full_reg & w_full_reg;
  wire rd_fire = ar_full_reg;
  wire aw_full_next = (aw_full_reg | aw_take) & ~wr_fire;
  wire w_full_next = (w_full_reg | w_take) & ~wr_fire;
  wire ar_full_next = (ar_full_reg | ar_take) & ~rd_fire;
  wire bvalid_next = wr_fire | (bvalid_o & ~bready_i);
  wire rvalid_next = rd_fire | (rvalid_o & ~rready_i);
  assign wr_o = '{fire: wr_fire, addr: awaddr_reg, data: wdata_reg,
    strb: wstrb_reg};
  assign rd_o = '{fire: rd_fire, addr: araddr_reg};
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      ar_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      araddr_reg <= 8'h00;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'h0;
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      arready_o <= 1'b0;
      bvalid_o <= 1'b0;
      rvalid_o <= 1'b0;
      bresp_o <= ibk_pkg::RESP_OKAY;
      rresp_o <= ibk_pkg::RESP_OKAY;
      rdata_o <= 32'h0000_0000;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      ar_full_reg <= ar_full_next;
      if (aw_take) awaddr_reg <= awaddr_i;
      if (w_take) wdata_reg <= wdata_i[15:0];
      if (w_take) wstrb_reg <= wstrb_i[1:0];
      if (ar_take) araddr_reg <= araddr_i;
      // readies held low until the response is gone
      awready_o <= ~aw_full_next & ~bvalid_next;
      wready_o <= ~w_full_next & ~bvalid_next;
      arready_o <= ~ar_full_next & ~rvalid_next;
      bvalid_o <= bvalid_next;
      rvalid_o <= rvalid_next;
      if (wr_fire) begin
        bresp_o <= wr_err_i ? ibk_pkg::RESP_SLVERR : ibk_pkg::RESP_OKAY;
      end
      if (rd_fire) begin
        rresp_o <= rd_err_i ? ibk_pkg::RESP_SLVERR : ibk_pkg::RESP_OKAY;
        rdata_o <= {16'h0000, rd_data_i};
      end
    end
  end
endmodule // axil_reg_port

/* File: src/ibk_pkg.sv */
// Purpose: constants and carriers for the flag and enable bank
// Assumes: 16-bit registers on a 32-bit register bus
// Notes: offsets are byte addresses
package ibk_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  // byte offsets
  localparam logic [7:0] OFF_FLAGS4 = 8'h00;
  localparam logic [7:0] OFF_EN0 = 8'h04;
  localparam logic [7:0] OFF_EN1 = 8'h08;
  localparam logic [7:0] OFF_EN2 = 8'h0C;
  localparam logic [7:0] OFF_EN4 = 8'h10;
  // implemented bits and reset value
  localparam logic [15:0] MASK_F4 = 16'h00F6;
  localparam logic [15:0] MASK_E0 = 16'h7FFF;
  localparam logic [15:0] MASK_E1 = 16'hFFFB;
  localparam logic [15:0] MASK_E2 = 16'hDFFF;
  localparam logic [15:0] MASK_E4 = 16'h00F6;
  localparam logic [15:0] RST_VAL = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // group 4 flag positions
  localparam int F4_CAN_B_TX = 7;
  localparam int F4_CAN_A_TX = 6;
  localparam int F4_DMA_CH7 = 5;
  localparam int F4_DMA_CH6 = 4;
  localparam int F4_UART_B_ERR = 2;
  localparam int F4_UART_A_ERR = 1;
  // group 0 enable positions
  localparam int E0_DMA_CH1 = 14;
  localparam int E0_ADC_A = 13;
  localparam int E0_UART_A_TX = 12;
  localparam int E0_UART_A_RX = 11;
  localparam int E0_SPI_A_EVT = 10;
  localparam int E0_SPI_A_ERR = 9;
  localparam int E0_TIMER3 = 8;
  localparam int E0_TIMER2 = 7;
  localparam int E0_CMP_CH2 = 6;
  localparam int E0_CAP_CH2 = 5;
  localparam int E0_DMA_CH0 = 4;
  localparam int E0_TIMER1 = 3;
  localparam int E0_CMP_CH1 = 2;
  localparam int E0_CAP_CH1 = 1;
  localparam int E0_EXT_PIN0 = 0;
  // group 1 enable positions
  localparam int E1_UART_B_TX = 15;
  localparam int E1_UART_B_RX = 14;
  localparam int E1_EXT_PIN2 = 13;
  localparam int E1_TIMER5 = 12;
  localparam int E1_TIMER4 = 11;
  localparam int E1_CMP_CH4 = 10;
  localparam int E1_CMP_CH3 = 9;
  localparam int E1_DMA_CH2 = 8;
  localparam int E1_CAP_CH8 = 7;
  localparam int E1_CAP_CH7 = 6;
  localparam int E1_ADC_B = 5;
  localparam int E1_EXT_PIN1 = 4;
  localparam int E1_PIN_CHG = 3;
  localparam int E1_I2C_A_MST = 1;
  localparam int E1_I2C_A_SLV = 0;
  // group 2 enable positions
  localparam int E2_TIMER6 = 15;
  localparam int E2_DMA_CH4 = 14;
  localparam int E2_CMP_CH8 = 12;
  localparam int E2_CMP_CH7 = 11;
  localparam int E2_CMP_CH6 = 10;
  localparam int E2_CMP_CH5 = 9;
  localparam int E2_CAP_CH6 = 8;
  localparam int E2_CAP_CH5 = 7;
  localparam int E2_CAP_CH4 = 6;
  localparam int E2_CAP_CH3 = 5;
  localparam int E2_DMA_CH3 = 4;
  localparam int E2_CAN_A_EVT = 3;
  localparam int E2_CAN_A_RX = 2;
  localparam int E2_SPI_B_EVT = 1;
  localparam int E2_SPI_B_ERR = 0;
  typedef struct packed {
    logic fire;
    logic [7:0] addr;
    logic [15:0] data;
    logic [1:0] strb;
  } reg_wr_t;
  typedef struct packed {
    logic fire;
    logic [7:0] addr;
  } reg_rd_t;
  function automatic logic addr_hit(input logic [7:0] a);
    return (a == OFF_FLAGS4) || (a == OFF_EN0) || (a == OFF_EN1) ||
      (a == OFF_EN2) || (a == OFF_EN4);
  endfunction
  function automatic logic [15:0] merge(input logic [15:0] old,
    input logic [15:0] data, input logic [1:0] strb,
    input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}};
    return ((data & m) | (old & ~m)) & mask;
  endfunction
endpackage

/* File: src/irq_flag_enable_bank.sv */
// Purpose: group 4 pending flags and group 0-2 source enables
// Assumes: request inputs are one-cycle pulses on CLK_I
// Notes: forwarded requests are registered, one cycle late
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/100ps
module irq_flag_enable_bank (
  // clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // AXI4-Lite write
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic [2:0] S_AXI_AWPROT_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  // AXI4-Lite read
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic [2:0] S_AXI_ARPROT_I,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  // group 4 request pulses
  input wire logic CAN_B_TX_REQ_I,
  input wire logic CAN_A_TX_REQ_I,
  input wire logic DMA_CH7_DONE_I,
  input wire logic DMA_CH6_DONE_I,
  input wire logic UART_B_ERR_I,
  input wire logic UART_A_ERR_I,
  // pending levels of groups 0-2
  input wire logic [15:0] PEND0_I,
  input wire logic [15:0] PEND1_I,
  input wire logic [15:0] PEND2_I,
  // gated requests to the cpu
  output logic [15:0] FWD0_O,
  output logic [15:0] FWD1_O,
  output logic [15:0] FWD2_O,
  output logic [15:0] FWD4_O
);
  ibk_pkg::reg_wr_t wr;
  ibk_pkg::reg_rd_t rd;
  logic [15:0] flags_reg, en0_reg, en1_reg, en2_reg, en4_reg;
  logic [15:0] fwd0_reg, fwd1_reg, fwd2_reg, fwd4_reg;
  logic [15:0] flags_vec, en0_vec, en1_vec, en2_vec, en4_vec;
  logic [15:0] set_vec, rd_data;
  logic rd_err, wr_err;

  axil_reg_port u_port (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .awvalid_i(S_AXI_AWVALID_I),
    .awready_o(S_AXI_AWREADY_O),
    .awaddr_i(S_AXI_AWADDR_I),
    .wvalid_i(S_AXI_WVALID_I),
    .wready_o(S_AXI_WREADY_O),
    .wdata_i(S_AXI_WDATA_I),
    .wstrb_i(S_AXI_WSTRB_I),
    .bvalid_o(S_AXI_BVALID_O),
    .bready_i(S_AXI_BREADY_I),
    .bresp_o(S_AXI_BRESP_O),
    .arvalid_i(S_AXI_ARVALID_I),
    .arready_o(S_AXI_ARREADY_O),
    .araddr_i(S_AXI_ARADDR_I),
    .rvalid_o(S_AXI_RVALID_O),
    .rready_i(S_AXI_RREADY_I),
    .rdata_o(S_AXI_RDATA_O),
    .rresp_o(S_AXI_RRESP_O),
    .wr_o(wr),
    .rd_o(rd),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err),
    .wr_err_i(wr_err)
  );

  // group 4 flag fields
  // CAN tx, DMA done and UART error flags
  wire can_b_tx_request_flag = flags_reg[ibk_pkg::F4_CAN_B_TX];
  wire can_a_tx_request_flag = flags_reg[ibk_pkg::F4_CAN_A_TX];
  wire dma_ch7_done_flag = flags_reg[ibk_pkg::F4_DMA_CH7];
  wire dma_ch6_done_flag = flags_reg[ibk_pkg::F4_DMA_CH6];
  wire uart_b_error_flag = flags_reg[ibk_pkg::F4_UART_B_ERR];
  wire uart_a_error_flag = flags_reg[ibk_pkg::F4_UART_A_ERR];

  wire dma_ch1_done_enable = en0_reg[ibk_pkg::E0_DMA_CH1];
  wire adc_a_done_enable = en0_reg[ibk_pkg::E0_ADC_A];
  wire uart_a_tx_enable = en0_reg[ibk_pkg::E0_UART_A_TX];
  wire uart_a_rx_enable = en0_reg[ibk_pkg::E0_UART_A_RX];
  wire spi_a_event_enable = en0_reg[ibk_pkg::E0_SPI_A_EVT];
  wire spi_a_error_enable = en0_reg[ibk_pkg::E0_SPI_A_ERR];
  wire timer3_irq_enable = en0_reg[ibk_pkg::E0_TIMER3];
  wire timer2_irq_enable = en0_reg[ibk_pkg::E0_TIMER2];
  wire compare_ch2_enable = en0_reg[ibk_pkg::E0_CMP_CH2];
  wire capture_ch2_enable = en0_reg[ibk_pkg::E0_CAP_CH2];
  wire dma_ch0_done_enable = en0_reg[ibk_pkg::E0_DMA_CH0];
  wire timer1_irq_enable = en0_reg[ibk_pkg::E0_TIMER1];
  wire compare_ch1_enable = en0_reg[ibk_pkg::E0_CMP_CH1];
  wire capture_ch1_enable = en0_reg[ibk_pkg::E0_CAP_CH1];
  wire ext_pin0_enable = en0_reg[ibk_pkg::E0_EXT_PIN0];

  wire uart_b_tx_enable = en1_reg[ibk_pkg::E1_UART_B_TX];
  wire uart_b_rx_enable = en1_reg[ibk_pkg::E1_UART_B_RX];
  wire ext_pin2_enable = en1_reg[ibk_pkg::E1_EXT_PIN2];
  wire timer5_irq_enable = en1_reg[ibk_pkg::E1_TIMER5];
  wire timer4_irq_enable = en1_reg[ibk_pkg::E1_TIMER4];
  wire compare_ch4_enable = en1_reg[ibk_pkg::E1_CMP_CH4];
  wire compare_ch3_enable = en1_reg[ibk_pkg::E1_CMP_CH3];
  wire dma_ch2_done_enable = en1_reg[ibk_pkg::E1_DMA_CH2];
  wire capture_ch8_enable = en1_reg[ibk_pkg::E1_CAP_CH8];
  wire capture_ch7_enable = en1_reg[ibk_pkg::E1_CAP_CH7];
  wire adc_b_done_enable = en1_reg[ibk_pkg::E1_ADC_B];
  wire ext_pin1_enable = en1_reg[ibk_pkg::E1_EXT_PIN1];
  wire pin_change_notify_enable = en1_reg[ibk_pkg::E1_PIN_CHG];
  wire i2c_a_master_event_enable = en1_reg[ibk_pkg::E1_I2C_A_MST];
  wire i2c_a_slave_event_enable = en1_reg[ibk_pkg::E1_I2C_A_SLV];

  wire timer6_irq_enable = en2_reg[ibk_pkg::E2_TIMER6];
  wire dma_ch4_done_enable = en2_reg[ibk_pkg::E2_DMA_CH4];
  wire compare_ch8_enable = en2_reg[ibk_pkg::E2_CMP_CH8];
  wire compare_ch7_enable = en2_reg[ibk_pkg::E2_CMP_CH7];
  wire compare_ch6_enable = en2_reg[ibk_pkg::E2_CMP_CH6];
  wire compare_ch5_enable = en2_reg[ibk_pkg::E2_CMP_CH5];
  wire capture_ch6_enable = en2_reg[ibk_pkg::E2_CAP_CH6];
  wire capture_ch5_enable = en2_reg[ibk_pkg::E2_CAP_CH5];
  wire capture_ch4_enable = en2_reg[ibk_pkg::E2_CAP_CH4];
  wire capture_ch3_enable = en2_reg[ibk_pkg::E2_CAP_CH3];
  wire dma_ch3_done_enable = en2_reg[ibk_pkg::E2_DMA_CH3];
  wire can_a_event_enable = en2_reg[ibk_pkg::E2_CAN_A_EVT];
  wire can_a_rx_ready_enable = en2_reg[ibk_pkg::E2_CAN_A_RX];
  wire spi_b_event_enable = en2_reg[ibk_pkg::E2_SPI_B_EVT];
  wire spi_b_error_enable = en2_reg[ibk_pkg::E2_SPI_B_ERR];

  assign flags_vec = {
    8'h00,
    can_b_tx_request_flag,
    can_a_tx_request_flag,
    dma_ch7_done_flag,
    dma_ch6_done_flag,
    1'b0,
    uart_b_error_flag,
    uart_a_error_flag,
    1'b0
  };
  assign en0_vec = {
    1'b0,
    dma_ch1_done_enable,
    adc_a_done_enable,
    uart_a_tx_enable,
    uart_a_rx_enable,
    spi_a_event_enable,
    spi_a_error_enable,
    timer3_irq_enable,
    timer2_irq_enable,
    compare_ch2_enable,
    capture_ch2_enable,
    dma_ch0_done_enable,
    timer1_irq_enable,
    compare_ch1_enable,
    capture_ch1_enable,
    ext_pin0_enable
  };
  assign en1_vec = {
    uart_b_tx_enable,
    uart_b_rx_enable,
    ext_pin2_enable,
    timer5_irq_enable,
    timer4_irq_enable,
    compare_ch4_enable,
    compare_ch3_enable,
    dma_ch2_done_enable,
    capture_ch8_enable,
    capture_ch7_enable,
    adc_b_done_enable,
    ext_pin1_enable,
    pin_change_notify_enable,
    1'b0,
    i2c_a_master_event_enable,
    i2c_a_slave_event_enable
  };
  assign en2_vec = {
    timer6_irq_enable,
    dma_ch4_done_enable,
    1'b0,
    compare_ch8_enable,
    compare_ch7_enable,
    compare_ch6_enable,
    compare_ch5_enable,
    capture_ch6_enable,
    capture_ch5_enable,
    capture_ch4_enable,
    capture_ch3_enable,
    dma_ch3_done_enable,
    can_a_event_enable,
    can_a_rx_ready_enable,
    spi_b_event_enable,
    spi_b_error_enable
  };
  // group4 enables are local, the forward path needs a gate
  assign en4_vec = en4_reg & ibk_pkg::MASK_E4;

  assign set_vec = {
    8'h00,
    CAN_B_TX_REQ_I,
    CAN_A_TX_REQ_I,
    DMA_CH7_DONE_I,
    DMA_CH6_DONE_I,
    1'b0,
    UART_B_ERR_I,
    UART_A_ERR_I,
    1'b0
  };

  // write decode
  // unmapped writes answer with an error and store nothing
  wire wr_f4 = wr.fire & (wr.addr == ibk_pkg::OFF_FLAGS4);
  wire wr_e0 = wr.fire & (wr.addr == ibk_pkg::OFF_EN0);
  wire wr_e1 = wr.fire & (wr.addr == ibk_pkg::OFF_EN1);
  wire wr_e2 = wr.fire & (wr.addr == ibk_pkg::OFF_EN2);
  wire wr_e4 = wr.fire & (wr.addr == ibk_pkg::OFF_EN4);
  assign wr_err = ~ibk_pkg::addr_hit(wr.addr);

  wire [15:0] flags_sw = wr_f4 ?
    ibk_pkg::merge(flags_reg, wr.data, wr.strb, ibk_pkg::MASK_F4) :
    flags_reg;
  wire [15:0] flags_next = (flags_sw | set_vec) & ibk_pkg::MASK_F4;
  wire [15:0] en0_next = wr_e0 ?
    ibk_pkg::merge(en0_reg, wr.data, wr.strb, ibk_pkg::MASK_E0) :
    en0_reg;
  wire [15:0] en1_next = wr_e1 ?
    ibk_pkg::merge(en1_reg, wr.data, wr.strb, ibk_pkg::MASK_E1) :
    en1_reg;
  wire [15:0] en2_next = wr_e2 ?
    ibk_pkg::merge(en2_reg, wr.data, wr.strb, ibk_pkg::MASK_E2) :
    en2_reg;
  wire [15:0] en4_next = wr_e4 ?
    ibk_pkg::merge(en4_reg, wr.data, wr.strb, ibk_pkg::MASK_E4) :
    en4_reg;

  wire [15:0] fwd0_next = PEND0_I & en0_vec;
  wire [15:0] fwd1_next = PEND1_I & en1_vec;
  wire [15:0] fwd2_next = PEND2_I & en2_vec;
  wire [15:0] fwd4_next = flags_vec & en4_vec;

  // read decode
  wire rd_f4 = rd.addr == ibk_pkg::OFF_FLAGS4;
  wire rd_e0 = rd.addr == ibk_pkg::OFF_EN0;
  wire rd_e1 = rd.addr == ibk_pkg::OFF_EN1;
  wire rd_e2 = rd.addr == ibk_pkg::OFF_EN2;
  wire rd_e4 = rd.addr == ibk_pkg::OFF_EN4;

  // read mux, unmapped reads return zero
  // holes read zero because the vectors are rebuilt or masked, not raw
  assign rd_err = ~ibk_pkg::addr_hit(rd.addr);
  assign rd_data =
    rd_f4 ? flags_vec :
    rd_e0 ? en0_vec :
    rd_e1 ? en1_vec :
    rd_e2 ? en2_vec :
    rd_e4 ? en4_vec :
    ibk_pkg::ZERO16;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      flags_reg <= ibk_pkg::RST_VAL;
      en0_reg <= ibk_pkg::RST_VAL;
      en1_reg <= ibk_pkg::RST_VAL;
      en2_reg <= ibk_pkg::RST_VAL;
      en4_reg <= ibk_pkg::RST_VAL;
    end else begin
      flags_reg <= flags_next;
      en0_reg <= en0_next;
      en1_reg <= en1_next;
      en2_reg <= en2_next;
      en4_reg <= en4_next;
    end
  end

  // registered so the cpu sees glitch-free levels
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      fwd0_reg <= ibk_pkg::RST_VAL;
      fwd1_reg <= ibk_pkg::RST_VAL;
      fwd2_reg <= ibk_pkg::RST_VAL;
      fwd4_reg <= ibk_pkg::RST_VAL;
    end else begin
      fwd0_reg <= fwd0_next;
      fwd1_reg <= fwd1_next;
      fwd2_reg <= fwd2_next;
      fwd4_reg <= fwd4_next;
    end
  end

  assign FWD0_O = fwd0_reg;
  assign FWD1_O = fwd1_reg;
  assign FWD2_O = fwd2_reg;
  assign FWD4_O = fwd4_reg;
endmodule // irq_flag_enable_bank
